// ### verilog/sensor_ctrl_cfg.svh
// timing and counter-width constants of the safety sensor output controller
`ifndef SENSOR_CTRL_CFG_SVH
`define SENSOR_CTRL_CFG_SVH
`define CLK_PERIOD_PS        4000
`define ACTIVATION_DELAY_US  9000
`define INTERVENTION_DELAY_US 9000
// cycles = delay in ns over period in ns; kept inside 32-bit arithmetic
`define ACTIVATION_CYCLES    ((`ACTIVATION_DELAY_US * 1000) / (`CLK_PERIOD_PS / 1000))
`define INTERVENTION_CYCLES  ((`INTERVENTION_DELAY_US * 1000) / (`CLK_PERIOD_PS / 1000))
`define DELAY_CNT_W          24
`endif

// ### verilog/sensor_ctrl_pkg.sv
// types of the safety sensor output controller
package sensor_ctrl_pkg;
   typedef enum logic [1:0] {CH_OFF, CH_ARMING, CH_ON, CH_TRIPPING} chan_state_type;
endpackage

// ### verilog/sync_two_ff.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_ff;  // first stage, read only by second
   logic nxt_meta;
   logic nxt_sync;

   // next values of both stages
   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
   end

   // register both stages
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_ff  <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_ff  <= nxt_meta;
         sync_out <= nxt_sync;
      end
   end
endmodule
`default_nettype wire

// ### verilog/safety_sensor_output_controller.sv
// two-channel safety sensor output controller
// Summary of operation
// - reset terminal wiring selects automatic or manual
// - supply indicator lit whenever powered
// - automatic power-up: after delay, outputs on
// - sensor pressed or broken: outputs off after delay
// - automatic: release re-activates after activation delay
// - single channel trip drops only that channel
// - automatic: reset contact ignored while active
// - manual power-up: outputs off until reset
// - manual: close-then-open reset, then activation delay
// - manual: after trip, new reset sequence needed
// - activation delay below ten milliseconds
// - intervention delay below ten milliseconds
// - signalling contact closed only when both active
`timescale 1ns/100ps
`default_nettype none
`include "sensor_ctrl_cfg.svh"
module safety_sensor_output_controller
   import sensor_ctrl_pkg::*;
#(
   parameter logic [`DELAY_CNT_W-1:0] ACT_CNT = `DELAY_CNT_W'(`ACTIVATION_CYCLES),
   parameter logic [`DELAY_CNT_W-1:0] INT_CNT = `DELAY_CNT_W'(`INTERVENTION_CYCLES)
)
(
   input  wire logic CLK,
   input  wire logic RST_N,
   input  wire logic SENSOR_CH1_PRESSED,
   input  wire logic SENSOR_CH2_PRESSED,
   input  wire logic RESET_AUTO_CLOSED,
   input  wire logic RESET_MANUAL_CLOSED,
   output logic      SAFETY_SWITCHING_OUTPUT_1,
   output logic      SAFETY_SWITCHING_OUTPUT_2,
   output logic      CHANNEL_ONE_INDICATOR,
   output logic      CHANNEL_TWO_INDICATOR,
   output logic      SUPPLY_INDICATOR,
   output logic      SIGNAL_CONTACT_CLOSED
);
   logic s_ch1;        // synchronised sensor channel one
   logic s_ch2;        // synchronised sensor channel two
   logic s_auto;       // synchronised automatic terminal
   logic s_man;        // synchronised manual terminal

   // synchronisers for every sensor and reset-terminal input
   sync_two_ff u_sync_ch1 (.clk(CLK), .rst_n(RST_N), .async_in(SENSOR_CH1_PRESSED), .sync_out(s_ch1));
   sync_two_ff u_sync_ch2 (.clk(CLK), .rst_n(RST_N), .async_in(SENSOR_CH2_PRESSED), .sync_out(s_ch2));
   sync_two_ff u_sync_aut (.clk(CLK), .rst_n(RST_N), .async_in(RESET_AUTO_CLOSED), .sync_out(s_auto));
   sync_two_ff u_sync_man (.clk(CLK), .rst_n(RST_N), .async_in(RESET_MANUAL_CLOSED), .sync_out(s_man));

   logic man_prev_ff;  // previous manual contact level
   logic armed_ff;     // manual reset released, grant pending
   logic nxt_man_prev;
   logic nxt_armed;
   logic release_pulse; // opening edge of manual contact
   logic auto_mode;     // automatic restart selected
   logic permit;        // restart condition for both channels

   chan_state_type st_ff [2];     // per-channel state
   chan_state_type nxt_st [2];
   logic [`DELAY_CNT_W-1:0] cnt_ff [2]; // per-channel delay counter
   logic [`DELAY_CNT_W-1:0] nxt_cnt [2];
   logic pressed [2];             // per-channel activation
   logic on_now [2];              // next output value per channel

   logic nxt_o1;
   logic nxt_o2;
   logic nxt_sig;

   // mode selection and manual reset edge detection
   always_comb begin
      auto_mode     = s_auto;
      release_pulse = man_prev_ff & ~s_man;
      nxt_man_prev  = s_man;
      nxt_armed     = armed_ff;
      if (auto_mode) begin
         nxt_armed = 1'b0;
      end else if (release_pulse) begin
         nxt_armed = 1'b1;
      end else if (st_ff[0] == CH_ON && st_ff[1] == CH_ON) begin
         nxt_armed = 1'b0;                      // grant consumed
      end else if (pressed[0] | pressed[1]) begin
         nxt_armed = 1'b0;
      end
      permit = auto_mode | (~auto_mode & armed_ff);
   end

   // register reset-sequence state
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         man_prev_ff <= 1'b0;
         armed_ff    <= 1'b0;
      end else begin
         man_prev_ff <= nxt_man_prev;
         armed_ff    <= nxt_armed;
      end
   end

   // per-channel state machines; off and arming check both channels
   always_comb begin
      pressed[0] = s_ch1;
      pressed[1] = s_ch2;
      for (int i = 0; i < 2; i++) begin
         nxt_st[i]  = st_ff[i];
         nxt_cnt[i] = cnt_ff[i];
         case (st_ff[i])
            CH_OFF: begin
               nxt_cnt[i] = '0;
               if (permit && !pressed[0] && !pressed[1]) begin
                  nxt_st[i] = CH_ARMING;
               end
            end
            CH_ARMING: begin
               if (pressed[0] || pressed[1] || !permit) begin
                  nxt_st[i]  = CH_OFF;          // condition lost
                  nxt_cnt[i] = '0;
               end else if (cnt_ff[i] >= ACT_CNT - 1'b1) begin
                  nxt_st[i]  = CH_ON;
                  nxt_cnt[i] = '0;
               end else begin
                  nxt_cnt[i] = cnt_ff[i] + 1'b1;
               end
            end
            CH_ON: begin
               nxt_cnt[i] = '0;
               if (pressed[i]) begin
                  nxt_st[i] = CH_TRIPPING;      // reset contact ignored
               end
            end
            CH_TRIPPING: begin
               if (cnt_ff[i] >= INT_CNT - 1'b1) begin
                  nxt_st[i]  = CH_OFF;
                  nxt_cnt[i] = '0;
               end else begin
                  nxt_cnt[i] = cnt_ff[i] + 1'b1;
               end
            end
            default: begin
               nxt_st[i]  = CH_OFF;
               nxt_cnt[i] = '0;
            end
         endcase
         on_now[i] = (nxt_st[i] == CH_ON) || (nxt_st[i] == CH_TRIPPING);
      end
      nxt_o1  = on_now[0];
      nxt_o2  = on_now[1];
      nxt_sig = on_now[0] & on_now[1];
   end

   // register channel states and outputs
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < 2; i++) begin
            st_ff[i]  <= CH_OFF;
            cnt_ff[i] <= '0;
         end
         SAFETY_SWITCHING_OUTPUT_1 <= 1'b0;
         SAFETY_SWITCHING_OUTPUT_2 <= 1'b0;
         CHANNEL_ONE_INDICATOR     <= 1'b0;
         CHANNEL_TWO_INDICATOR     <= 1'b0;
         SIGNAL_CONTACT_CLOSED     <= 1'b0;
         SUPPLY_INDICATOR          <= 1'b1;
      end else begin
         for (int i = 0; i < 2; i++) begin
            st_ff[i]  <= nxt_st[i];
            cnt_ff[i] <= nxt_cnt[i];
         end
         SAFETY_SWITCHING_OUTPUT_1 <= nxt_o1;
         SAFETY_SWITCHING_OUTPUT_2 <= nxt_o2;
         CHANNEL_ONE_INDICATOR     <= nxt_o1;
         CHANNEL_TWO_INDICATOR     <= nxt_o2;
         SIGNAL_CONTACT_CLOSED     <= nxt_sig;
         SUPPLY_INDICATOR          <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### test/ssoc_monitor.sv
// checker of the controller ports; assumes the bench's 250-cycle delays
`timescale 1ns/100ps
`default_nettype none
module ssoc_monitor (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic SENSOR_CH1_PRESSED,
   input wire logic SENSOR_CH2_PRESSED,
   input wire logic SAFETY_SWITCHING_OUTPUT_1,
   input wire logic SAFETY_SWITCHING_OUTPUT_2,
   input wire logic CHANNEL_ONE_INDICATOR,
   input wire logic CHANNEL_TWO_INDICATOR,
   input wire logic SUPPLY_INDICATOR,
   input wire logic SIGNAL_CONTACT_CLOSED
);
   logic [8:0] held_ff;  // cycles channel one held, saturating
   logic [8:0] nxt_held; // next hold count
   // count a steady press; a release or reset clears it
   always_comb nxt_held = (!RST_N || !SENSOR_CH1_PRESSED) ? 9'h000 : held_ff + {8'h00, held_ff != 9'h1FF};
   always_ff @(posedge CLK) held_ff <= nxt_held;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // both channels released well before any rise
   sequence calm_s; !$past(SENSOR_CH1_PRESSED, 8) && !$past(SENSOR_CH2_PRESSED, 8); endsequence
   supply_lit_a: assert property (SUPPLY_INDICATOR) else $error("supply dark");
   ind_one_a: assert property (CHANNEL_ONE_INDICATOR == SAFETY_SWITCHING_OUTPUT_1) else $error("ind one");
   ind_two_a: assert property (CHANNEL_TWO_INDICATOR == SAFETY_SWITCHING_OUTPUT_2) else $error("ind two");
   sig_both_a: assert property (SIGNAL_CONTACT_CLOSED == (SAFETY_SWITCHING_OUTPUT_1 && SAFETY_SWITCHING_OUTPUT_2))
      else $error("signal contact");
   rise_one_a: assert property ($rose(SAFETY_SWITCHING_OUTPUT_1) |-> calm_s) else $error("rise one");
   rise_two_a: assert property ($rose(SAFETY_SWITCHING_OUTPUT_2) |-> calm_s) else $error("rise two");
   quiet_start_a: assert property ($rose(RST_N) |-> !SAFETY_SWITCHING_OUTPUT_1 [*8]) else $error("early on");
   trip_done_a: assert property (held_ff > 9'h110 |-> !SAFETY_SWITCHING_OUTPUT_1) else $error("no trip");
endmodule
bind safety_sensor_output_controller ssoc_monitor ssoc_monitor_inst (.*);
`default_nettype wire

// ### test/contact_model.sv
// sensor mat contacts and reset contact wiring
`timescale 1ns/100ps
`default_nettype none
module contact_model (
   input  wire logic press1,      // channel one pressed
   input  wire logic press2,      // channel two pressed
   input  wire logic auto_sel,    // contact on automatic terminal
   input  wire logic btn,         // reset button held
   output logic      sens1,       // channel one contact
   output logic      sens2,       // channel two contact
   output logic      auto_closed, // automatic terminal
   output logic      man_closed   // manual terminal
);
   assign sens1 = press1;
   assign sens2 = press2;
   // wiring picks the terminal; the button opens the automatic loop and closes the manual one
   assign auto_closed = auto_sel & ~btn;
   assign man_closed = ~auto_sel & btn;
endmodule
`default_nettype wire

// ### test/safety_sensor_output_controller_bench.sv
// self-checking bench of the safety sensor output controller
`timescale 1ns/100ps
`default_nettype none
module safety_sensor_output_controller_bench;
   localparam int D = 262; // delay plus synchroniser margin
   logic clk = 1'b0, rst_n = 1'b0, p1 = 1'b0, p2 = 1'b0, auto_sel = 1'b1, btn = 1'b0;
   logic s1, s2, ac, mc, o1, o2, i1, i2, sup, sig;
   int mismatches = 0, num_checks = 0, cyc = 0;
   always #2 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   contact_model contact_model_inst (.press1(p1), .press2(p2), .auto_sel(auto_sel), .btn(btn),
      .sens1(s1), .sens2(s2), .auto_closed(ac), .man_closed(mc));
   // short delays so the run stays brief
   safety_sensor_output_controller #(.ACT_CNT(24'h0000FA), .INT_CNT(24'h0000FA))
      safety_sensor_output_controller_inst (.CLK(clk), .RST_N(rst_n),
      .SENSOR_CH1_PRESSED(s1), .SENSOR_CH2_PRESSED(s2), .RESET_AUTO_CLOSED(ac), .RESET_MANUAL_CLOSED(mc),
      .SAFETY_SWITCHING_OUTPUT_1(o1), .SAFETY_SWITCHING_OUTPUT_2(o2), .CHANNEL_ONE_INDICATOR(i1),
      .CHANNEL_TWO_INDICATOR(i2), .SUPPLY_INDICATOR(sup), .SIGNAL_CONTACT_CLOSED(sig));
   task automatic chk(input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %b want %b", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // all outputs against two expected channel levels
   task automatic outs(input logic e1, input logic e2);
      chk(o1, e1);
      chk(o2, e2);
      chk(i1, e1);
      chk(i2, e2);
      chk(sig, e1 & e2);
      chk(sup, 1'b1);
   endtask
   task automatic boot(input logic a);
      auto_sel = a;
      rst_n = 1'b0;
      wt(12);
      rst_n = 1'b1;
   endtask
   task automatic push(input logic a, input logic b);
      p1 = a;
      p2 = b;
      wt(D);
   endtask
   task automatic tap();
      btn = 1'b1;
      wt(8);
      btn = 1'b0;
      wt(D);
   endtask
   task automatic t_auto();
      boot(1'b1);
      wt(8);
      outs(1'b0, 1'b0);
      wt(D);
      outs(1'b1, 1'b1);
      btn = 1'b1;
      wt(4);
      btn = 1'b0;
      wt(D);
      outs(1'b1, 1'b1);
   endtask
   task automatic t_trip();
      push(1'b1, 1'b0);
      outs(1'b0, 1'b1);
      push(1'b0, 1'b0);
      outs(1'b1, 1'b1);
      p1 = 1'b1;
      p2 = 1'b1;
      wt(125);
      outs(1'b1, 1'b1);
      wt(D);
      outs(1'b0, 1'b0);
      push(1'b0, 1'b0);
      outs(1'b1, 1'b1);
   endtask
   task automatic t_manual();
      boot(1'b0);
      wt(D);
      outs(1'b0, 1'b0);
      tap();
      outs(1'b1, 1'b1);
      push(1'b1, 1'b1);
      push(1'b0, 1'b0);
      outs(1'b0, 1'b0);
      tap();
      outs(1'b1, 1'b1);
   endtask
   task automatic wrap_up();
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      t_auto();
      t_trip();
      t_manual();
      wrap_up();
   end
endmodule
`default_nettype wire
